// [hdl/rx_event_status_flags.sv]
// receive event status flags with read-clear and masked interrupt request
`timescale 1ns/10ps
// =====================================================
// Overview of operation
// - 8-bit status at 0x08, reset 0x00; B flags bits 7:4, A bits 3:0.
// - on each load, completeness flag = 1 only if all eight bits valid.
// - completeness flags are status only, never raise an interrupt.
// - channel B frame end after programmed idle bit times once reception began.
// - frame-end flag reads 1 while pending, 0 otherwise.
// - reading the status register clears channel B frame end.
// - channel B full set on any transfer into its holding register.
// - full flag reads 1 while pending, 0 otherwise.
// - each condition interrupts only when its enable bit is 1.
// - zero length gives frame end at first invalid bit after valid.
// - channel A frame end behaves like channel B.
// - channel A full set on any transfer into its holding register.
module rx_event_status_flags
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire rx_event_status_pkg::chan_evt_t I_CHAN_A,
    input wire rx_event_status_pkg::chan_evt_t I_CHAN_B,
    input wire logic [2:0] I_GAP_LEN,
    input wire logic [7:0] I_IRQ_ENABLE,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    output logic [7:0] O_STATUS,
    output logic O_FRAME_END_A,
    output logic O_FRAME_END_B,
    output logic O_IRQ
);
    import rx_event_status_pkg::*;

    // =====================================================
    // shared decode
    logic status_rd;
    logic [7:0] status;
    logic [NIBBLE_W-1:0] nibble [NUM_CHAN];
    logic [NUM_CHAN-1:0] frame_end;
    chan_evt_t chan [NUM_CHAN];

    assign chan[0] = I_CHAN_A;
    assign chan[1] = I_CHAN_B;

    // only the status address clears; data register reads never clear the flags
    assign status_rd = I_REG_RD && (I_REG_ADDR == REG_RX_EVENT_STATUS);

    // =====================================================
    // per-channel state: frame tracking, holding occupancy, status nibble
    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++)
        begin : g_chan
            localparam int B = c * NIBBLE_W;
            logic in_frame;
            logic next_in_frame;
            logic [2:0] gap_cnt;
            logic [2:0] next_gap_cnt;
            logic gap_done;
            logic holding_full;
            logic next_holding_full;
            logic overflow;
            logic underflow;
            logic [NIBBLE_W-1:0] flags;
            logic [NIBBLE_W-1:0] next_flags;

            // a gap of length N ends at the (N+1)th idle bit; N=0 fires on the first
            assign gap_done = (gap_cnt == I_GAP_LEN);
            assign frame_end[c] = in_frame && chan[c].bit_tick && !chan[c].bit_valid
                && gap_done;

            // =====================================================
            // frame tracking
            always_comb
            begin
                next_in_frame = in_frame;
                next_gap_cnt = gap_cnt;
                if (chan[c].bit_tick && chan[c].bit_valid)
                begin
                    next_in_frame = 1'b1;
                    next_gap_cnt = 3'h0;
                end
                else if (frame_end[c])
                begin
                    next_in_frame = 1'b0;
                    next_gap_cnt = 3'h0;
                end
                else if (in_frame && chan[c].bit_tick)
                begin
                    // cannot wrap: frame end fires at the latest when the count meets 7
                    next_gap_cnt = gap_cnt + 3'h1;
                end
            end

            always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
            begin
                if (!I_RESET_N)
                begin
                    in_frame <= 1'b0;
                    gap_cnt <= GAP_LEN_RESET;
                end
                else
                begin
                    in_frame <= next_in_frame;
                    gap_cnt <= next_gap_cnt;
                end
            end

            // =====================================================
            // holding register occupancy: load fills, host data read empties
            // a load and a data read together count as a refill, not an overflow
            assign overflow = chan[c].load && holding_full && !chan[c].data_read;
            assign underflow = chan[c].data_read && !holding_full;

            always_comb
            begin
                next_holding_full = holding_full;
                if (chan[c].data_read)
                begin
                    next_holding_full = 1'b0;
                end
                if (chan[c].load)
                begin
                    next_holding_full = 1'b1;
                end
            end

            always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
            begin
                if (!I_RESET_N)
                begin
                    holding_full <= 1'b0;
                end
                else
                begin
                    holding_full <= next_holding_full;
                end
            end

            // =====================================================
            // status nibble: read-clear of pending flags, sets win in the same cycle
            always_comb
            begin
                next_flags = flags;
                if (status_rd)
                begin
                    // completeness is plain status and survives the read
                    next_flags[FLD_FULL] = 1'b0;
                    next_flags[FLD_FRAME_END] = 1'b0;
                    next_flags[FLD_FLOW] = 1'b0;
                end
                if (chan[c].load)
                begin
                    next_flags[FLD_COMPLETE] = &chan[c].valid;
                    next_flags[FLD_FULL] = 1'b1;
                end
                if (overflow || underflow)
                begin
                    next_flags[FLD_FLOW] = 1'b1;
                end
                if (frame_end[c])
                begin
                    next_flags[FLD_FRAME_END] = 1'b1;
                end
            end

            always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
            begin
                if (!I_RESET_N)
                begin
                    flags <= STATUS_RESET[B +: NIBBLE_W];
                end
                else
                begin
                    flags <= next_flags;
                end
            end

            assign nibble[c] = flags;
        end
    endgenerate

    // =====================================================
    // outputs
    assign status = {nibble[1], nibble[0]};

    logic [7:0] irq_cond;
    genvar k;
    generate
        for (k = 0; k < 8; k++)
        begin : g_irq
            if ((k % NIBBLE_W) == FLD_COMPLETE)
            begin : g_status_only
                // completeness bits never request service
                assign irq_cond[k] = 1'b0;
            end
            else
            begin : g_can_interrupt
                // a disabled condition stays visible in status only
                assign irq_cond[k] = status[k] && I_IRQ_ENABLE[k];
            end
        end
    endgenerate

    assign O_STATUS = status;
    assign O_FRAME_END_A = frame_end[0];
    assign O_FRAME_END_B = frame_end[1];

    // level request: drops as soon as the read-clear empties every enabled flag
    assign O_IRQ = |irq_cond;
endmodule : rx_event_status_flags

// [hdl/rx_event_status_pkg.sv]
// constants and carrier types for the receive event status block
package rx_event_status_pkg;
    // =====================================================
    // register map
    localparam logic [7:0] REG_RX_EVENT_STATUS = 8'h08;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // =====================================================
    // field positions within one channel nibble
    localparam int FLD_FULL = 0;
    localparam int FLD_FRAME_END = 1;
    localparam int FLD_FLOW = 2;
    localparam int FLD_COMPLETE = 3;
    localparam int NIBBLE_W = 4;
    localparam int NUM_CHAN = 2;
    localparam logic [2:0] GAP_LEN_RESET = 3'h0;
    // =====================================================
    // per-channel receiver events
    typedef struct packed {
        logic load;       // byte moved into holding register
        logic [7:0] valid; // per-bit valid mask of the loaded byte
        logic bit_tick;   // one pulse per bit time
        logic bit_valid;  // a correlated bit in this bit time
        logic data_read;  // host read of the channel data register
    } chan_evt_t;
endpackage : rx_event_status_pkg

// [tb/rx_event_status_flags_assertions.sv]
// port-level checks for the receive event status block
`timescale 1ns/10ps
module rx_event_status_flags_assertions
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire rx_event_status_pkg::chan_evt_t I_CHAN_A,
    input wire rx_event_status_pkg::chan_evt_t I_CHAN_B,
    input wire logic [2:0] I_GAP_LEN,
    input wire logic [7:0] I_IRQ_ENABLE,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] O_STATUS,
    input wire logic O_FRAME_END_A,
    input wire logic O_FRAME_END_B,
    input wire logic O_IRQ
);
    import rx_event_status_pkg::*;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);
    // no event strobes: set-beats-clear cannot mask a read-clear
    wire quiet = !(I_CHAN_A.load | I_CHAN_A.bit_tick | I_CHAN_A.data_read
        | I_CHAN_B.load | I_CHAN_B.bit_tick | I_CHAN_B.data_read);
    sequence s_gap_zero;
        I_CHAN_B.bit_tick && I_CHAN_B.bit_valid ##1 !I_CHAN_B.bit_tick
        ##1 I_CHAN_B.bit_tick && !I_CHAN_B.bit_valid && I_GAP_LEN == 3'h0;
    endsequence
    // ====
    // properties
    a_irq_enabled: assert property (O_IRQ == |(O_STATUS & I_IRQ_ENABLE & 8'h77))
        else $error("irq mismatch");
    a_read_clear: assert property (I_REG_RD && I_REG_ADDR == 8'h08 && quiet
        |=> (O_STATUS & 8'h77) == 8'h00) else $error("read clear");
    a_flags_hold: assert property (!(I_REG_RD && I_REG_ADDR == 8'h08)
        |=> (~O_STATUS & $past(O_STATUS) & 8'h77) == 8'h00) else $error("flag lost");
    a_complete_a: assert property (I_CHAN_A.load |=> O_STATUS[3] == &$past(I_CHAN_A.valid))
        else $error("complete A");
    a_complete_b: assert property (I_CHAN_B.load |=> O_STATUS[7] == &$past(I_CHAN_B.valid))
        else $error("complete B");
    a_full_a: assert property (I_CHAN_A.load |=> O_STATUS[0]) else $error("full A");
    a_full_b: assert property (I_CHAN_B.load |=> O_STATUS[4]) else $error("full B");
    a_gap_zero: assert property (s_gap_zero |-> O_FRAME_END_B ##1 O_STATUS[5])
        else $error("zero gap frame end");
endmodule : rx_event_status_flags_assertions
bind rx_event_status_flags rx_event_status_flags_assertions chk (.*);

// [tb/host_reader.sv]
// host side model: issues register read strobes to the given address
`timescale 1ns/10ps
module host_reader
(
    input wire logic i_clk,
    output logic o_rd = 1'b0,
    output logic [7:0] o_addr = 8'h00
);
    // strobe and address held to the sampling edge, then released
    task read(input logic [7:0] a);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
    endtask : read
endmodule : host_reader

// [tb/rx_event_status_flags_test.sv]
// self-checking bench for the receive event status block
`timescale 1ns/10ps
module rx_event_status_flags_test;
    import rx_event_status_pkg::*;
    logic clk = 0, rst_n = 0, rd, fea, feb, fa, fb, irq;
    logic [7:0] addr, st, en = 8'hFF;
    logic [2:0] gap = 3'h0;
    chan_evt_t ca = '0, cb = '0;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    // rows: valid A, valid B, status after both loads
    logic [23:0] rows [3] = '{24'hFF0019, 24'h0FFF91, 24'hFFFF99};
    always #5 clk = ~clk;
    host_reader host (.i_clk(clk), .o_rd(rd), .o_addr(addr));
    rx_event_status_flags dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_CHAN_A(ca),
        .I_CHAN_B(cb), .I_GAP_LEN(gap), .I_IRQ_ENABLE(en), .I_REG_RD(rd), .I_REG_ADDR(addr),
        .O_STATUS(st), .O_FRAME_END_A(fea), .O_FRAME_END_B(feb), .O_IRQ(irq));
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task chk(input logic [8:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle event strobes; frame-end pulse captured while strobes stand
    task pulse(input chan_evt_t a, b);
        @(posedge clk);
        ca <= a;
        cb <= b;
        #1 fa = fea;
        fb = feb;
        @(posedge clk);
        ca <= '0;
        cb <= '0;
        #1;
    endtask : pulse
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 400)
        begin
            n_mismatch++;
            summarize();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(st, 8'h00);
        foreach (rows[i])
        begin
            pulse({1'b1, rows[i][23:16], 3'h0}, {1'b1, rows[i][15:8], 3'h0});
            chk(st, rows[i][7:0]);
            pulse(12'h001, 12'h001);
            host.read(8'h08);
            #1 chk(st, rows[i][7:0] & 8'h88);
        end
        pulse({1'b1, 8'hFF, 3'h0}, 12'h000);
        pulse({1'b1, 8'h0F, 3'h0}, 12'h001);
        chk(st, 8'hC5);
        chk({7'h0, irq}, 8'h01);
        @(posedge clk) en <= 8'h00;
        host.read(8'h09);
        #1 chk({st, irq}, {8'hC5, 1'b0});
        @(posedge clk) en <= 8'hFF;
        host.read(8'h08);
        #1 chk({st, irq}, {8'h80, 1'b0});
        // ====
        // frame end after 0..2 idle bit times, both channels at once
        for (int g = 0; g < 3; g++)
        begin
            @(posedge clk) gap <= g[2:0];
            pulse(12'h006, 12'h006);
            for (int i = 0; i <= g; i++)
            begin
                pulse(12'h004, 12'h004);
                chk({fa, fb}, (i == g) ? 8'h03 : 8'h00);
            end
            chk(st & 8'h22, 8'h22);
            host.read(8'h08);
            #1 chk(st & 8'h22, 8'h00);
        end
        summarize();
    end
endmodule : rx_event_status_flags_test
